// ---- gps_pkg.sv ----
// shared constants for the gigabit status register block
package gps_pkg;

  // register port widths
  localparam int unsigned GPS_ADDR_W = 5;
  localparam int unsigned GPS_DATA_W = 16;

  // register offsets; the interrupt pair is placed above the phy range
  localparam logic [4:0] GPS_OFF_GIGABIT_STATUS = 5'h04;
  localparam logic [4:0] GPS_OFF_IRQ_STATUS     = 5'h10;
  localparam logic [4:0] GPS_OFF_IRQ_MASK       = 5'h11;

  // gigabit_status field positions
  localparam int unsigned GPS_BIT_MANUAL_CFG_FAULT   = 15;
  localparam int unsigned GPS_BIT_ROLE_RESOLUTION    = 14;
  localparam int unsigned GPS_BIT_LOCAL_RECEIVER_OK  = 13;
  localparam int unsigned GPS_BIT_REMOTE_RECEIVER_OK = 12;
  localparam int unsigned GPS_BIT_PARTNER_GIG_FD     = 11;
  localparam int unsigned GPS_BIT_PARTNER_GIG_HD     = 10;
  localparam int unsigned GPS_RESERVED_BITS_MSB      = 9;
  localparam int unsigned GPS_RESERVED_BITS_LSB      = 8;
  localparam int unsigned GPS_IDLE_CNT_MSB           = 7;
  localparam int unsigned GPS_IDLE_CNT_LSB           = 0;
  localparam int unsigned GPS_IDLE_CNT_W             = 8;

  // values after reset
  localparam logic [15:0] GPS_GIGABIT_STATUS_RST = 16'h0000;
  localparam logic [15:0] GPS_RDATA_RST          = 16'h0000;
  localparam logic [4:0]  GPS_IRQ_STATUS_RST     = 5'h00;
  localparam logic [4:0]  GPS_IRQ_MASK_RST       = 5'h00;

  // idle error counter limits
  localparam logic [7:0] GPS_IDLE_CNT_MAX = 8'hFF;
  localparam logic [7:0] GPS_IDLE_CNT_PRE = 8'hFE;

  // failed role resolutions before the fault latches
  localparam int unsigned GPS_FAIL_CNT_W    = 3;
  localparam logic [2:0]  GPS_FAIL_LIMIT    = 3'h7;
  localparam logic [2:0]  GPS_FAIL_PRE      = 3'h6;

  // interrupt event bit positions
  localparam int unsigned GPS_IRQ_W          = 5;
  localparam int unsigned GPS_EV_FAULT       = 0;
  localparam int unsigned GPS_EV_IDLE_ERR    = 1;
  localparam int unsigned GPS_EV_IDLE_SAT    = 2;
  localparam int unsigned GPS_EV_LOCAL_RX    = 3;
  localparam int unsigned GPS_EV_REMOTE_RX   = 4;

endpackage : gps_pkg

// ---- gps_sat_cnt.sv ----
`timescale 1ns/10ps
`default_nettype none

// saturating up counter; a count in the clear cycle survives as one
module gps_sat_cnt #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         clk_en_in,
  input  wire logic         clr_in,
  input  wire logic         inc_in,
  output logic      [W-1:0] cnt_out,
  output logic              at_max_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } gps_cnt_state_t;

  gps_cnt_state_t st_q;
  gps_cnt_state_t st_d;

  // next count: clear first, but a same-cycle increment is kept
  always_comb begin
    st_d = st_q;
    if (clr_in) begin
      st_d.cnt = inc_in ? W'(1) : '0;
    end else if (inc_in && (st_q.cnt != {W{1'b1}})) begin
      st_d.cnt = W'(st_q.cnt + W'(1));
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign cnt_out    = st_q.cnt;
  assign at_max_out = (st_q.cnt == {W{1'b1}});

endmodule : gps_sat_cnt

`default_nettype wire

// ---- gps_status_reg.sv ----
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - fault latches after seven failed role resolutions
// - reading gigabit_status clears the fault flag
// - fault self-clears on autoneg enable or complete
// - bit 14 shows master or slave result
// - bit 13 shows local receiver ok
// - bit 12 shows remote receiver ok
// - bit 11 shows partner gigabit full duplex
// - bit 10 shows partner gigabit half duplex
// - idle errors counted only in idle, send_n
// - one count per errored symbol period
// - counter clears on read and pcs reset
// - counter saturates at all ones
module gps_status_reg (
  input  wire logic                         clk_in,
  input  wire logic                         resetn_in,
  input  wire logic                         clk_en_in,
  input  wire logic [gps_pkg::GPS_ADDR_W-1:0] addr_in,
  input  wire logic [gps_pkg::GPS_DATA_W-1:0] wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [gps_pkg::GPS_DATA_W-1:0] rdata_out,
  output logic                              irq_out,
  input  wire logic                         ms_fail_in,
  input  wire logic                         an_enable_in,
  input  wire logic                         an_complete_in,
  input  wire logic                         role_master_in,
  input  wire logic                         local_receiver_ok_in,
  input  wire logic                         remote_receiver_ok_in,
  input  wire logic                         partner_gig_full_duplex_in,
  input  wire logic                         partner_gig_half_duplex_in,
  input  wire logic                         rx_idle_in,
  input  wire logic                         tx_mode_send_n_in,
  input  wire logic                         symbol_tick_in,
  input  wire logic                         rx_error_in,
  input  wire logic                         pcs_reset_in
);
  import gps_pkg::*;

  typedef struct packed {
    logic [GPS_DATA_W-1:0] rdata;
    logic                  irq;
    logic                  manual_cfg_fault;
    logic                  an_enable_prev;
    logic                  an_complete_prev;
    logic                  local_ok_prev;
    logic                  remote_ok_prev;
    logic [GPS_IRQ_W-1:0]  irq_status;
    logic [GPS_IRQ_W-1:0]  irq_mask;
  } gps_state_t;

  gps_state_t st_q;
  gps_state_t st_d;

  logic                      rd_gigabit_status;
  logic                      wr_irq_status;
  logic                      wr_irq_mask;
  logic                      an_enable_rise;
  logic                      an_complete_rise;
  logic                      an_clear;
  logic                      fault_set;
  logic                      idle_qualified;
  logic                      idle_inc;
  logic                      idle_clr;
  logic [GPS_IDLE_CNT_W-1:0] idle_cnt;
  logic                      idle_at_max;
  logic [GPS_FAIL_CNT_W-1:0] fail_cnt;
  logic [GPS_IRQ_W-1:0]      irq_events;
  logic [GPS_IRQ_W-1:0]      irq_w1c;
  logic [GPS_IRQ_W-1:0]      irq_status_nxt;
  logic [GPS_DATA_W-1:0]     gigabit_status_word;

  // address decode of the plain register port
  assign rd_gigabit_status      = rd_in && (addr_in == GPS_OFF_GIGABIT_STATUS);
  assign wr_irq_status = wr_in && (addr_in == GPS_OFF_IRQ_STATUS);
  assign wr_irq_mask   = wr_in && (addr_in == GPS_OFF_IRQ_MASK);

  // autoneg enable and completion act on their rising edges
  assign an_enable_rise   = an_enable_in && !st_q.an_enable_prev;
  assign an_complete_rise = an_complete_in && !st_q.an_complete_prev;
  assign an_clear         = an_enable_rise || an_complete_rise;

  // seventh failure latches the fault; saturated count keeps re-arming it
  assign fault_set = ms_fail_in && (fail_cnt >= GPS_FAIL_PRE);

  // failed resolution tally, restarted by each new negotiation
  gps_sat_cnt #(
    .W (GPS_FAIL_CNT_W)
  ) u_fail_cnt (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .clk_en_in  (clk_en_in),
    .clr_in     (an_clear),
    .inc_in     (ms_fail_in),
    .cnt_out    (fail_cnt),
    .at_max_out ()
  );

  // idle errors only count in idle with transmit mode send_n
  assign idle_qualified = rx_idle_in && tx_mode_send_n_in;
  assign idle_inc       = idle_qualified && symbol_tick_in && rx_error_in;
  assign idle_clr       = rd_gigabit_status || pcs_reset_in;

  // counter holds at all ones; a clear with an error leaves one
  gps_sat_cnt #(
    .W (GPS_IDLE_CNT_W)
  ) u_idle_cnt (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .clk_en_in  (clk_en_in),
    .clr_in     (idle_clr),
    .inc_in     (idle_inc),
    .cnt_out    (idle_cnt),
    .at_max_out (idle_at_max)
  );

  // live status word; reserved bits read back as zero
  always_comb begin
    gigabit_status_word = GPS_GIGABIT_STATUS_RST;
    gigabit_status_word[GPS_BIT_MANUAL_CFG_FAULT]   = st_q.manual_cfg_fault;
    gigabit_status_word[GPS_BIT_ROLE_RESOLUTION]    = role_master_in;
    gigabit_status_word[GPS_BIT_LOCAL_RECEIVER_OK]  = local_receiver_ok_in;
    gigabit_status_word[GPS_BIT_REMOTE_RECEIVER_OK] = remote_receiver_ok_in;
    gigabit_status_word[GPS_BIT_PARTNER_GIG_FD]     = partner_gig_full_duplex_in;
    gigabit_status_word[GPS_BIT_PARTNER_GIG_HD]     = partner_gig_half_duplex_in;
    gigabit_status_word[GPS_IDLE_CNT_MSB:GPS_IDLE_CNT_LSB] = idle_cnt;
  end

  // events feeding the sticky interrupt status
  always_comb begin
    irq_events = '0;
    irq_events[GPS_EV_FAULT]     = fault_set;
    irq_events[GPS_EV_IDLE_ERR]  = idle_inc;
    irq_events[GPS_EV_IDLE_SAT]  = idle_inc && (idle_clr ? 1'b0 : (idle_cnt == GPS_IDLE_CNT_PRE));
    irq_events[GPS_EV_LOCAL_RX]  = local_receiver_ok_in != st_q.local_ok_prev;
    irq_events[GPS_EV_REMOTE_RX] = remote_receiver_ok_in != st_q.remote_ok_prev;
    irq_w1c = wr_irq_status ? wdata_in[GPS_IRQ_W-1:0] : '0;
  end

  // per bit write-one-to-clear; a new event beats the clear
  for (genvar i = 0; i < GPS_IRQ_W; i++) begin : g_irq_bit
    assign irq_status_nxt[i] = irq_events[i] || (st_q.irq_status[i] && !irq_w1c[i]);
  end

  // next state of the register file except the two counters
  always_comb begin
    st_d = st_q;
    st_d.an_enable_prev   = an_enable_in;
    st_d.an_complete_prev = an_complete_in;
    st_d.local_ok_prev    = local_receiver_ok_in;
    st_d.remote_ok_prev   = remote_receiver_ok_in;
    // read data stand for one cycle only, zero otherwise
    st_d.rdata = GPS_RDATA_RST;
    if (rd_in) begin
      case (addr_in)
        GPS_OFF_GIGABIT_STATUS: begin
          st_d.rdata = gigabit_status_word;
        end
        GPS_OFF_IRQ_STATUS: begin
          st_d.rdata[GPS_IRQ_W-1:0] = st_q.irq_status;
        end
        GPS_OFF_IRQ_MASK: begin
          st_d.rdata[GPS_IRQ_W-1:0] = st_q.irq_mask;
        end
        default: begin
          st_d.rdata = GPS_RDATA_RST;
        end
      endcase
    end
    // fault: set wins over read clear and autoneg clear
    if (fault_set) begin
      st_d.manual_cfg_fault = 1'b1;
    end else if (rd_gigabit_status) begin
      st_d.manual_cfg_fault = 1'b0;
    end else if (an_clear) begin
      st_d.manual_cfg_fault = 1'b0;
    end
    // gigabit_status writes are dropped; reserved bits have no storage
    if (wr_irq_mask) begin
      st_d.irq_mask = wdata_in[GPS_IRQ_W-1:0];
    end
    st_d.irq_status = irq_status_nxt;
    // level interrupt from next values, so a mask write shows at once
    st_d.irq = |(st_d.irq_status & st_d.irq_mask);
  end

  // one register for all state but the two counters; frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  // outputs come straight from the state register
  assign rdata_out = st_q.rdata;
  assign irq_out   = st_q.irq;

  // checks on the fault latch, read port, idle counter and idle error interrupt

  // the seventh failure must latch the fault
  a_fault_latch: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && ms_fail_in && (fail_cnt >= GPS_FAIL_PRE))
    |=> st_q.manual_cfg_fault
  ) else $error("fault flag did not latch");

  // a read with no new fault clears the flag
  a_fault_rd_clear: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status && !fault_set)
    |=> !st_q.manual_cfg_fault
  ) else $error("fault flag survived a read");

  // autoneg enable or complete clears the flag
  a_fault_an_clear: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && an_clear && !fault_set)
    |=> !st_q.manual_cfg_fault
  ) else $error("fault flag survived autoneg");

  // latched flag holds until a clear
  a_fault_hold: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && st_q.manual_cfg_fault && !rd_gigabit_status && !an_clear)
    |=> st_q.manual_cfg_fault
  ) else $error("fault flag dropped by itself");

  // no latch before the seventh failure
  a_fault_early: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && !st_q.manual_cfg_fault && !(ms_fail_in && (fail_cnt >= GPS_FAIL_PRE)))
    |=> !st_q.manual_cfg_fault
  ) else $error("fault flag set too early");

  // read data carry the role resolution
  a_read_role: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_ROLE_RESOLUTION] == $past(role_master_in)
  ) else $error("role bit wrong on read");

  // read data carry local receiver status
  a_read_local_ok: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_LOCAL_RECEIVER_OK] == $past(local_receiver_ok_in)
  ) else $error("local receiver bit wrong on read");

  // read data carry remote receiver status
  a_read_remote_ok: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_REMOTE_RECEIVER_OK] == $past(remote_receiver_ok_in)
  ) else $error("remote receiver bit wrong on read");

  // read data carry partner full duplex ability
  a_read_part_fd: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_PARTNER_GIG_FD] == $past(partner_gig_full_duplex_in)
  ) else $error("partner full duplex bit wrong on read");

  // read data carry partner half duplex ability
  a_read_part_hd: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_PARTNER_GIG_HD] == $past(partner_gig_half_duplex_in)
  ) else $error("partner half duplex bit wrong on read");

  // a read returns the count from before its own clear
  a_read_cnt_pre: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_IDLE_CNT_MSB:GPS_IDLE_CNT_LSB] == $past(idle_cnt)
  ) else $error("read count not the pre-clear value");

  // a read returns the fault from before its own clear
  a_read_flt_pre: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_BIT_MANUAL_CFG_FAULT] == $past(st_q.manual_cfg_fault)
  ) else $error("read fault not the pre-clear value");

  // outside idle with send_n the counter stands still
  a_idle_no_count: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && !(rx_idle_in && tx_mode_send_n_in) && !rd_gigabit_status && !pcs_reset_in)
    |=> idle_cnt == $past(idle_cnt)
  ) else $error("idle counter moved outside idle");

  // one errored symbol adds exactly one
  a_idle_cnt_step: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && !rd_gigabit_status && !pcs_reset_in && rx_idle_in && tx_mode_send_n_in && symbol_tick_in && rx_error_in && (idle_cnt != GPS_IDLE_CNT_MAX))
    |=> idle_cnt == 8'($past(idle_cnt) + 8'h01)
  ) else $error("idle counter did not step by one");

  // no symbol tick, no count
  a_idle_no_tick: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && !rd_gigabit_status && !pcs_reset_in && !symbol_tick_in)
    |=> idle_cnt == $past(idle_cnt)
  ) else $error("idle counter moved without a tick");

  // read or pcs reset with no error clears to zero
  a_idle_clear: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && (rd_gigabit_status || pcs_reset_in) && !rx_error_in)
    |=> idle_cnt == '0
  ) else $error("idle counter not cleared");

  // at all ones the counter stays there
  a_idle_saturate: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && (idle_cnt == GPS_IDLE_CNT_MAX) && !rd_gigabit_status && !pcs_reset_in)
    |=> idle_cnt == GPS_IDLE_CNT_MAX
  ) else $error("idle counter wrapped");

  // an error in the clearing cycle is kept as one
  a_idle_clr_keep: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status && rx_idle_in && tx_mode_send_n_in && symbol_tick_in && rx_error_in)
    |=> idle_cnt == 8'h01
  ) else $error("idle error lost in clearing cycle");

  // a counted idle error is flagged in the interrupt status
  a_irq_idle_event: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rx_idle_in && tx_mode_send_n_in && symbol_tick_in && rx_error_in)
    |=> st_q.irq_status[GPS_EV_IDLE_ERR]
  ) else $error("idle error event not flagged");

  // reserved bits read back as zero
  a_reserved_zero: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && rd_gigabit_status)
    |=> rdata_out[GPS_RESERVED_BITS_MSB:GPS_RESERVED_BITS_LSB] == 2'b00
  ) else $error("reserved bits not zero");

  // read data stand only in the cycle after a read
  a_rdata_quiet: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (clk_en_in && !rd_in)
    |=> rdata_out == '0
  ) else $error("read data outside the read cycle");

endmodule : gps_status_reg

`default_nettype wire

// ---- gps_link_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

// far-end phy: abilities change only on renegotiation, errors only while noisy
module gps_link_partner (
  input  wire logic clk_in,
  input  wire logic renew_in,
  input  wire logic noisy_in,
  output logic      remote_ok_out,
  output logic      gig_fd_out,
  output logic      gig_hd_out,
  output logic      tick_out,
  output logic      err_out
);
  initial {remote_ok_out, gig_fd_out, gig_hd_out, tick_out, err_out} = 5'h0;
  // symbol period of two clocks; random error flag keeps the counter honest
  always @(posedge clk_in) begin
    if (renew_in) {remote_ok_out, gig_fd_out, gig_hd_out} <= 3'($urandom);
    tick_out <= ~tick_out;
    err_out  <= noisy_in && ($urandom_range(1, 0) == 1);
  end
endmodule : gps_link_partner

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import gps_pkg::*;
  logic        clk_in, resetn_in, wr, rd, ms_fail, an_en, an_cmp, role, lok;
  logic        idle, send_n, pcs, renew, noisy, remote, fd, hd, tick, err, irq, ev;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, v, exp_q;
  logic [7:0]  cnt_q;
  logic        fault_q;
  int          fails_q, miscompares, tests_run, cycles;

  gps_status_reg gps_status_reg_inst (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .irq_out(irq), .ms_fail_in(ms_fail), .an_enable_in(an_en), .an_complete_in(an_cmp),
    .role_master_in(role), .local_receiver_ok_in(lok), .remote_receiver_ok_in(remote),
    .partner_gig_full_duplex_in(fd), .partner_gig_half_duplex_in(hd), .rx_idle_in(idle),
    .tx_mode_send_n_in(send_n), .symbol_tick_in(tick), .rx_error_in(err), .pcs_reset_in(pcs));
  gps_link_partner gps_link_partner_inst (.clk_in(clk_in), .renew_in(renew), .noisy_in(noisy),
    .remote_ok_out(remote), .gig_fd_out(fd), .gig_hd_out(hd), .tick_out(tick), .err_out(err));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // reference model; an event in a clearing cycle survives as a count of one
  always @(posedge clk_in or negedge resetn_in) begin
    ev = idle && send_n && tick && err;
    if (!resetn_in) begin
      {cnt_q, fault_q, fails_q} <= '0;
    end else begin
      if (rd && addr == GPS_OFF_GIGABIT_STATUS) begin
        exp_q <= {fault_q, role, lok, remote, fd, hd, 2'b00, cnt_q};
        cnt_q <= 8'(ev);
      end else if (pcs) begin
        cnt_q <= 8'(ev);
      end else if (ev && cnt_q != GPS_IDLE_CNT_MAX) begin
        cnt_q <= cnt_q + 8'h01;
      end
      if ((rd && addr == GPS_OFF_GIGABIT_STATUS) || an_en || an_cmp) begin
        fault_q <= 1'b0;
        fails_q <= 0;
      end else if (ms_fail) begin
        fails_q <= fails_q + 1;
        if (fails_q >= 6) fault_q <= 1'b1;
      end
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  // reserved bits are ignored on read
  task automatic rd_gs();
    bus_rd(GPS_OFF_GIGABIT_STATUS, v);
    chk(v & 16'hFCFF, exp_q, "gigabit status");
  endtask : rd_gs

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial begin
    {resetn_in, wr, rd, ms_fail, an_en, an_cmp, role, lok, idle, send_n, pcs} = '0;
    {renew, noisy, addr, wdata} = '0;
    void'($urandom(35259));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    bus_rd(GPS_OFF_GIGABIT_STATUS, v);
    chk(v, GPS_GIGABIT_STATUS_RST, "reset value");
    bus_wr(GPS_OFF_GIGABIT_STATUS, 16'h0000);
    // status fields follow their sources
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      {role, lok} <= 2'($urandom);
      renew <= 1'b1;
      @(posedge clk_in);
      renew <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd_gs();
    end
    // counting with reads landing at random, some back to back
    {lok, idle, send_n, noisy} <= 4'hF;
    repeat (40) begin
      repeat ($urandom_range(4, 0)) @(posedge clk_in);
      rd_gs();
    end
    send_n <= 1'b0;
    repeat (30) @(posedge clk_in);
    rd_gs();
    {idle, send_n} <= 2'b01;
    repeat (30) @(posedge clk_in);
    rd_gs();
    idle <= 1'b1;
    repeat (1500) @(posedge clk_in);
    rd_gs();
    repeat (200) @(posedge clk_in);
    send_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    pcs <= 1'b1;
    @(posedge clk_in);
    pcs <= 1'b0;
    rd_gs();
    // fault latch cleared by read, autoneg enable, autoneg complete
    for (int k = 0; k < 3; k++) begin
      repeat (7) begin
        @(posedge clk_in);
        ms_fail <= 1'b1;
        @(posedge clk_in);
        ms_fail <= 1'b0;
      end
      if (k == 0) rd_gs();
      @(posedge clk_in);
      an_en  <= (k == 1);
      an_cmp <= (k == 2);
      @(posedge clk_in);
      {an_en, an_cmp} <= 2'b00;
      rd_gs();
    end
    // interrupt: masked, unmasked, cleared by writing ones
    bus_wr(GPS_OFF_IRQ_MASK, 16'h0000);
    send_n <= 1'b1;
    repeat (30) @(posedge clk_in);
    chk(16'(irq), 16'h0000, "irq while masked");
    bus_wr(GPS_OFF_IRQ_MASK, 16'h001F);
    #1 chk(16'(irq), 16'h0001, "irq unmasked");
    bus_rd(GPS_OFF_IRQ_STATUS, v);
    chk(16'(v[GPS_EV_IDLE_ERR]), 16'h0001, "idle error event");
    {send_n, noisy} <= 2'b00;
    repeat (5) @(posedge clk_in);
    bus_wr(GPS_OFF_IRQ_STATUS, 16'h001F);
    bus_rd(GPS_OFF_IRQ_STATUS, v);
    chk(v, 16'h0000, "irq status cleared");
    chk(16'(irq), 16'h0000, "irq released");
    bus_rd(5'h1F, v);
    chk(v, 16'h0000, "unmapped read");
    close_out();
  end
endmodule : testbench

`default_nettype wire
